// >>> uhm_pkg.sv
package uhm_pkg;
  // ==========================================================
  // Command codes
  localparam logic [7:0] CMD_RD_CTRL = 8'h01;
  localparam logic [7:0] CMD_WR_CTRL = 8'h81;
  // ==========================================================
  // Field positions
  localparam int FS_LO = 6;
  localparam int FS_HI = 7;
  localparam int WCC_BIT = 9;
  localparam int RWE_BIT = 10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int SOF_DELAY_US = 1000;
  localparam int SOF_DELAY_CYC = SOF_DELAY_US * CLK_MHZ;
  // ==========================================================
  // Functional states
  typedef enum logic [1:0] {
    UHM_RESET = 2'h0,
    UHM_RESUME = 2'h1,
    UHM_OPER = 2'h2,
    UHM_SUSPEND = 2'h3
  } uhm_state_e;
endpackage : uhm_pkg

// >>> uhm_tmr_if.sv
`timescale 1ns/1ps
interface uhm_tmr_if;
  logic start;
  logic stop;
  logic done;
  modport ctrl (output start, output stop, input done);
  modport tmr (input start, input stop, output done);
endinterface : uhm_tmr_if

// >>> uhm_sof_timer.sv
`timescale 1ns/1ps
module uhm_sof_timer #(
  parameter int DELAY_CYC = uhm_pkg::SOF_DELAY_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  uhm_tmr_if.tmr tif
);
  logic [31:0] cnt_q;
  logic run_q;
  logic done_q;

  // ==========================================================
  // Delay count
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 32'h0000_0000;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end else if (tif.stop) begin
      run_q <= 1'b0;
      done_q <= 1'b0;
    end else if (tif.start) begin
      cnt_q <= 32'(DELAY_CYC - 1);
      run_q <= 1'b1;
      done_q <= 1'b0;
    end else if (run_q) begin
      if (cnt_q == 32'h0000_0000) begin
        run_q <= 1'b0;
        done_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q - 32'h0000_0001;
      end
    end
  end

  assign tif.done = done_q;
endmodule : uhm_sof_timer

// >>> uhm_mode_control.sv
// Function
// - Command 01H reads, command 81H writes the 32-bit mode control register.
// - Remote wake enable changes only through host driver writes and resets; soft reset clears it, but a write in the same cycle wins.
// - Wake enable plus resume-seen flag raises remote wake-up; interrupts unaffected.
// - Wake capable bit cleared by hardware reset, kept over software reset.
// - Entering operational state starts frame generation 1 ms later.
// - Device alters functional state itself only while suspended.
// - Suspended device moves to resume on downstream resume signaling.
// - Both resets put functional state to reset encoding 00B.
// - Hardware reset resets root hub and ports; software reset does not.
`timescale 1ns/1ps
module uhm_mode_control #(
  parameter int SOF_DELAY = uhm_pkg::SOF_DELAY_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [31:0] wr_data,
  output logic [31:0] rd_data,
  output logic rd_valid,
  input wire logic soft_reset,
  input wire logic port_resume,
  input wire logic resume_seen_flag,
  output logic remote_wakeup,
  output logic sof_enable,
  output logic root_hub_reset,
  output logic [1:0] functional_state
);
  logic wr_hit;
  logic rd_hit;
  logic rwe_q;
  logic wcc_q;
  logic hw_rst_q;
  logic [31:0] rd_q;
  logic rdv_q;
  logic [1:0] sync_in;
  logic [1:0] sync_out;
  logic res_sync;
  logic rsf_sync;
  logic [31:0] rd_word;
  logic sof_start;
  logic sof_stop;
  uhm_pkg::uhm_state_e fs_q;
  uhm_pkg::uhm_state_e fs_d;
  uhm_tmr_if tif ();

  // ==========================================================
  // Command decode
  function automatic logic cmd_is(
    input logic valid,
    input logic [7:0] code,
    input logic [7:0] want
  );
    return valid && (code == want);
  endfunction : cmd_is

  // ==========================================================
  // Register image
  function automatic logic [31:0] pack_ctrl(
    input logic remote_wake_enable,
    input logic wcc,
    input logic [1:0] fs
  );
    logic [31:0] word;
    word = uhm_pkg::CTRL_RESET;
    word[uhm_pkg::RWE_BIT] = remote_wake_enable;
    word[uhm_pkg::WCC_BIT] = wcc;
    word[uhm_pkg::FS_HI:uhm_pkg::FS_LO] = fs;
    return word;
  endfunction : pack_ctrl

  // ==========================================================
  // Command strobes
  assign wr_hit = cmd_is(cmd_valid, cmd_code, uhm_pkg::CMD_WR_CTRL);
  assign rd_hit = cmd_is(cmd_valid, cmd_code, uhm_pkg::CMD_RD_CTRL);

  // ==========================================================
  // Synchronisers for pin inputs
  assign sync_in = {resume_seen_flag, port_resume};

  for (genvar i = 0; i < 2; i++) begin : g_sync
    logic s1_q;
    logic s2_q;
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
      end else begin
        s1_q <= sync_in[i];
        s2_q <= s1_q;
      end
    end
    assign sync_out[i] = s2_q;
  end : g_sync

  assign res_sync = sync_out[0];
  assign rsf_sync = sync_out[1];

  // ==========================================================
  // Functional state
  always_comb begin
    fs_d = fs_q;
    if (wr_hit) begin
      fs_d = uhm_pkg::uhm_state_e'(wr_data[uhm_pkg::FS_HI:uhm_pkg::FS_LO]);
    end else begin
      case (fs_q)
        uhm_pkg::UHM_RESET: begin
          fs_d = uhm_pkg::UHM_RESET;
        end
        uhm_pkg::UHM_RESUME: begin
          fs_d = uhm_pkg::UHM_RESUME;
        end
        uhm_pkg::UHM_OPER: begin
          fs_d = uhm_pkg::UHM_OPER;
        end
        uhm_pkg::UHM_SUSPEND: begin
          if (res_sync) begin
            fs_d = uhm_pkg::UHM_RESUME;
          end
        end
        default: begin
          fs_d = fs_q;
        end
      endcase
    end
    if (soft_reset) begin
      fs_d = uhm_pkg::UHM_RESET;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fs_q <= uhm_pkg::UHM_RESET;
    end else begin
      fs_q <= fs_d;
    end
  end

  // ==========================================================
  // Wake bits
  // Enable moves only on host writes, cleared by soft reset; a write in the same cycle wins
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rwe_q <= 1'b0;
    end else if (wr_hit) begin
      rwe_q <= wr_data[uhm_pkg::RWE_BIT];
    end else if (soft_reset) begin
      rwe_q <= 1'b0;
    end
  end

  // Capable bit survives soft reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wcc_q <= 1'b0;
    end else if (wr_hit) begin
      wcc_q <= wr_data[uhm_pkg::WCC_BIT];
    end
  end

  // ==========================================================
  // Remote wake-up request
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      remote_wakeup <= 1'b0;
    end else begin
      remote_wakeup <= rwe_q && rsf_sync;
    end
  end

  // ==========================================================
  // Hardware reset pulse to root hub
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hw_rst_q <= 1'b1;
    end else begin
      hw_rst_q <= 1'b0;
    end
  end
  assign root_hub_reset = hw_rst_q;

  // ==========================================================
  // Frame start delay
  // Timer restarts on every entry, stops on any exit
  assign sof_start = (fs_d == uhm_pkg::UHM_OPER) &&
                     (fs_q != uhm_pkg::UHM_OPER);
  assign sof_stop = (fs_d != uhm_pkg::UHM_OPER);
  assign tif.start = sof_start;
  assign tif.stop = sof_stop;

  uhm_sof_timer #(.DELAY_CYC(SOF_DELAY)) u_tmr (
    .clock(clock),
    .reset_n(reset_n),
    .tif(tif.tmr)
  );
  assign sof_enable = tif.done;

  // ==========================================================
  // Read path
  assign rd_word = pack_ctrl(rwe_q, wcc_q, fs_q);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_q <= uhm_pkg::CTRL_RESET;
    end else if (rd_hit) begin
      rd_q <= rd_word;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdv_q <= 1'b0;
    end else begin
      rdv_q <= rd_hit;
    end
  end

  // ==========================================================
  // Outputs
  assign rd_data = rd_q;
  assign rd_valid = rdv_q;
  assign functional_state = fs_q;
endmodule : uhm_mode_control

// >>> uhm_mode_control_asserts.sv
`timescale 1ns/1ps
module uhm_mode_control_chk #(
  parameter int SOF_DELAY = uhm_pkg::SOF_DELAY_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [31:0] wr_data,
  input wire logic [31:0] rd_data,
  input wire logic rd_valid,
  input wire logic soft_reset,
  input wire logic port_resume,
  input wire logic resume_seen_flag,
  input wire logic remote_wakeup,
  input wire logic sof_enable,
  input wire logic root_hub_reset,
  input wire logic [1:0] functional_state
);
  // ====================
  // Cycles spent in the operational state
  logic [31:0] oper_cnt_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      oper_cnt_q <= 32'h0000_0000;
    end else if (functional_state != 2'h2) begin
      oper_cnt_q <= 32'h0000_0000;
    end else if (oper_cnt_q != 32'hFFFF_FFFF) begin
      oper_cnt_q <= oper_cnt_q + 32'h0000_0001;
    end
  end
  // ====================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_rdv; cmd_valid && cmd_code == 8'h01 |=> rd_valid; endproperty
  a_rdv: assert property (p_rdv) else $error("read late");
  property p_rsv; rd_valid |-> (rd_data & 32'hFFFFF93F) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  property p_wr; cmd_valid && cmd_code == 8'h81 && !soft_reset
    |=> functional_state == $past(wr_data[7:6]); endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_srst; soft_reset |=> functional_state == 2'h0; endproperty
  a_srst: assert property (p_srst) else $error("soft state");
  property p_rhub; soft_reset |=> !root_hub_reset; endproperty
  a_rhub: assert property (p_rhub) else $error("hub reset");
  property p_hold; functional_state != 2'h3 && !soft_reset &&
    !(cmd_valid && cmd_code == 8'h81) |=> $stable(functional_state);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved");
  property p_wake; !resume_seen_flag [*3] |=> !remote_wakeup; endproperty
  a_wake: assert property (p_wake) else $error("wake early");
  property p_sofo; (functional_state != 2'h2) [*2] |-> !sof_enable;
  endproperty
  a_sofo: assert property (p_sofo) else $error("sof on");
  property p_sofr; $rose(sof_enable)
    |-> oper_cnt_q == 32'(SOF_DELAY); endproperty
  a_sofr: assert property (p_sofr) else $error("sof early");
endmodule : uhm_mode_control_chk

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic soft_reset = 1'b0;
  logic port_resume = 1'b0;
  logic resume_seen_flag = 1'b0;
  logic [31:0] rd_data, d;
  logic rd_valid, remote_wakeup, sof_enable, root_hub_reset;
  logic [1:0] functional_state;
  int n_errors = 0;
  int total_checks = 0;
  int seed = 39977;
  uhm_mode_control #(.SOF_DELAY(20)) u_dut (.clock, .reset_n, .cmd_valid,
    .cmd_code, .wr_data, .rd_data, .rd_valid, .soft_reset, .port_resume,
    .resume_seen_flag, .remote_wakeup, .sof_enable, .root_hub_reset,
    .functional_state);
  initial begin
    forever #2 clock = ~clock;
  end
  // ====================
  // Tasks
  task close_out;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  task chk(input string n, input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task cmd(input logic [7:0] c, input logic [31:0] v);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    wr_data <= v;
    @(posedge clock);
    cmd_valid <= 1'b0;
  endtask : cmd
  task rd(input string n, input logic [31:0] e);
    cmd(8'h01, 32'h0);
    @(posedge clock);
    chk("rd_valid", 32'(rd_valid), 32'h1);
    chk(n, rd_data, e);
  endtask : rd
  function logic [31:0] fold(input logic [31:0] v);
    return v & 32'h000006C0;
  endfunction : fold
  // ====================
  // Scenarios
  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    rd("reset", 32'h0);
    d = $random(seed);
    d[10:6] = 5'h1A;
    cmd(8'h81, d);
    rd("write", fold(d));
    resume_seen_flag <= 1'b1;
    port_resume <= 1'b1;
    repeat (24) @(posedge clock);
    #1 chk("sof", 32'(sof_enable), 32'h1);
    chk("wake", 32'(remote_wakeup), 32'h1);
    chk("held", 32'(functional_state), 32'h2);
    cmd(8'h81, d | 32'h40);
    repeat (5) @(posedge clock);
    #1 chk("resume", 32'(functional_state), 32'h1);
    cmd(8'h02, 32'h0);
    rd("ignored", 32'h00000640);
    port_resume <= 1'b0;
    resume_seen_flag <= 1'b0;
    @(posedge clock);
    soft_reset <= 1'b1;
    @(posedge clock);
    soft_reset <= 1'b0;
    #1 chk("hub", 32'(root_hub_reset), 32'h0);
    rd("soft", 32'h00000200);
    repeat (16) begin
      d = $random(seed);
      cmd(8'h81, d);
      rd("random", fold(d));
    end
    @(posedge clock);
    reset_n <= 1'b0;
    #1 chk("hub hw", 32'(root_hub_reset), 32'h1);
    @(posedge clock);
    reset_n <= 1'b1;
    rd("hw", 32'h0);
    close_out;
  end
  initial begin
    #4000;
    n_errors++;
    close_out;
  end
endmodule : testbench
bind uhm_mode_control uhm_mode_control_chk #(.SOF_DELAY(SOF_DELAY)) u_chk (
  .clock, .reset_n, .cmd_valid, .cmd_code, .wr_data, .rd_data, .rd_valid,
  .soft_reset, .port_resume, .resume_seen_flag, .remote_wakeup,
  .sof_enable, .root_hub_reset, .functional_state);
